// *** rtl/csp_pkg.sv ***
// constants and register map of the clocked serial port
// assumes a single 40 MHz clock and a plain register port
//
// What this block does and what its software must do
// (RL1) master continuous: loading buffer into shifter pulses buffer-empty interrupt
// (RL2) master: no new data means clock stops and busy flag clears
// (RL3) software reads receive buffer on reception-error interrupt
// (RL4) writing 0 to overrun flag clears it
// (RL5) software disables port only after busy flag reads 0
// (RL6) slave continuous: full word without new write ends sequence, reception-end
// (RL7) continuous: reception completing while receive buffer unread sets overrun, error interrupt
// (RL8) overrun still overwrites receive buffer with new word
// (RL9) error interrupt repeats at each completion while buffer unread
// (RL10) software reads receive buffer before next word's last bit
// (RL11) powered off: clock pin floats on external select, else idle level
// (RL12) powered off: clock pin follows polarity and select immediately
// (RL13) powered off: data pin low, latch, or buffer bit 7/0
// (RL14) powered off: data pin follows enable, order, phase immediately
// (RL15) clock select 000 gives peripheral clock divided by two
// (RL16) clock select 111 takes external clock, slave mode
// (RL17) length field 0000 selects eight-bit words
// (RL18) bit order 0 shifts most significant bit first
// (RL19) polarity and phase both 0 give type 1 timing
// (RL20) busy flag sets on buffer write or dummy read, clears last edge
// (RL21) writing 1 to overrun flag does nothing
// (RL22) continuous: new data before word end continues without clock gap
package csp_pkg;
    // ********************************
    // register offsets
    // ********************************
    localparam logic [2:0] ADDR_CTL0 = 3'h0;
    localparam logic [2:0] ADDR_CTL1 = 3'h1;
    localparam logic [2:0] ADDR_LEN = 3'h2;
    localparam logic [2:0] ADDR_STATUS = 3'h3;
    localparam logic [2:0] ADDR_TX = 3'h4;
    localparam logic [2:0] ADDR_RX = 3'h5;
    // ********************************
    // field positions
    // ********************************
    localparam int B_PWR = 7;
    localparam int B_TXE = 6;
    localparam int B_RXE = 5;
    localparam int B_DIR = 4;
    localparam int B_CONT = 1;
    localparam int B_CKP = 4;
    localparam int B_DAP = 3;
    localparam int B_TSF = 7;
    localparam int B_OVE = 0;
    localparam int B_LOW7 = 7;
    localparam int B_LOW0 = 0;
    // ********************************
    // codes and reset values
    // ********************************
    localparam logic [2:0] CKS_EXT = 3'h7;
    localparam logic [3:0] LEN_DEFAULT_SEL = 4'h0;
    localparam logic [3:0] LEN_DEFAULT = 4'h8;
    localparam logic [7:0] CTL_RESET = 8'h00;
    localparam int DIV_W = 7;
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_LEAD = 3'b010,
        ST_TRAIL = 3'b100
    } csp_state_t;
endpackage

// *** rtl/csp_clkdiv.sv ***
// half-period tick divider for the master serial clock
// assumes clear is held while no master transfer runs
`timescale 1ns/1ps
module csp_clkdiv
    import csp_pkg::*;
(
    // clock and reset
    input wire logic i_ref_clk,
    input wire logic i_rst,
    // control
    input wire logic i_clear,
    input wire logic [2:0] i_sel,
    // tick
    output logic o_tick
);
    logic [DIV_W-1:0] cnt;
    wire logic [DIV_W-1:0] limit;

    // half period is 2^sel cycles, so select 0 ticks every cycle
    assign limit = DIV_W'((DIV_W'(1) << i_sel) - DIV_W'(1)); // [RL15]
    assign o_tick = !i_clear && (cnt == limit);

    always_ff @(posedge i_ref_clk) begin
        if (i_rst || i_clear || o_tick) begin
            cnt <= '0;
        end else begin
            cnt <= DIV_W'(cnt + DIV_W'(1));
        end
    end
endmodule

// *** rtl/csp_top.sv ***
// clocked serial port: registers, shift engine, pins
// assumes software on the register port and a serial peer on the pins
`timescale 1ns/1ps
module csp_top
    import csp_pkg::*;
#(
    parameter int DATA_W = 16
) (
    // clock and reset
    input wire logic i_ref_clk,
    input wire logic i_rst,
    // register port
    input wire logic [2:0] i_addr,
    input wire logic [DATA_W-1:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [DATA_W-1:0] o_rdata,
    // event pulses
    output logic o_tx_buffer_empty_irq,
    output logic o_rx_end_irq,
    output logic o_rx_error_irq,
    // serial pins
    input wire logic i_sck,
    output logic o_sck_out,
    output logic o_sck_oe,
    input wire logic i_si,
    output logic o_so
);
    // ********************************
    // helpers
    // ********************************
    function automatic logic [3:0] bit_pos(input logic lsb_first,
                                           input logic [3:0] len,
                                           input logic [3:0] idx);
        bit_pos = lsb_first ? idx : 4'(len - 4'h1 - idx); // [RL18]
    endfunction

    // ********************************
    // registers
    // ********************************
    logic [7:0] serial_control_0;
    logic [7:0] serial_control_1;
    logic [3:0] serial_length_control;
    logic [DATA_W-1:0] transmit_buffer;
    logic [DATA_W-1:0] receive_buffer;
    logic transfer_in_progress, overrun_flag;
    logic tx_pending, rx_dummy, rx_unread;

    wire logic operation_enable = serial_control_0[B_PWR];
    wire logic transmit_enable = serial_control_0[B_TXE];
    wire logic receive_enable = serial_control_0[B_RXE];
    wire logic bit_order = serial_control_0[B_DIR];
    wire logic cont_mode = serial_control_0[B_CONT];
    wire logic clock_polarity = serial_control_1[B_CKP];
    wire logic data_phase = serial_control_1[B_DAP];
    wire logic [2:0] clock_select = serial_control_1[2:0];

    wire logic wr_ctl0 = i_wr && (i_addr == ADDR_CTL0);
    wire logic wr_ctl1 = i_wr && (i_addr == ADDR_CTL1);
    wire logic wr_len = i_wr && (i_addr == ADDR_LEN);
    wire logic wr_stat = i_wr && (i_addr == ADDR_STATUS);
    wire logic wr_tx = i_wr && (i_addr == ADDR_TX);
    wire logic rd_rx = i_rd && (i_addr == ADDR_RX);

    // ********************************
    // engine signals
    // ********************************
    csp_state_t state;
    logic [3:0] bit_idx;
    logic [DATA_W-1:0] shift_word;
    logic [DATA_W-1:0] rx_word, next_rx_word;
    logic sck_lvl, so_latch;
    // master sampling waits out the two-flop delay on the data pin
    logic [5:0] rx_d1, rx_d2;
    logic sck_m1, sck_s, sck_d;
    logic si_m1, si_s;
    logic tick;

    wire logic master = (clock_select != CKS_EXT); // [RL16]
    wire logic idle_lvl = !clock_polarity; // [RL19]
    wire logic [3:0] len = (serial_length_control == LEN_DEFAULT_SEL) ?
                           LEN_DEFAULT : serial_length_control; // [RL17]
    wire logic sck_edge = (sck_s != sck_d);
    wire logic ext_lead = sck_edge && (sck_s != idle_lvl);
    wire logic ext_trail = sck_edge && (sck_s == idle_lvl);
    wire logic lead_ev = (state == ST_LEAD) && (master ? tick : ext_lead);
    wire logic trail_ev = (state == ST_TRAIL) && (master ? tick : ext_trail);
    wire logic last_bit = (bit_idx == 4'(len - 4'h1));
    wire logic word_done = trail_ev && last_bit;
    // [RL20]
    wire logic start_req = operation_enable &&
        ((transmit_enable && tx_pending) ||
         (!transmit_enable && receive_enable && rx_dummy));
    // [RL22]
    wire logic load = start_req &&
        ((state == ST_IDLE) || (word_done && cont_mode));
    wire logic sample_ev = data_phase ? lead_ev : trail_ev;
    wire logic drive_ev = data_phase ? (trail_ev && !last_bit) : lead_ev;
    wire logic [3:0] drive_idx = data_phase ? 4'(bit_idx + 4'h1) : bit_idx;
    wire logic [3:0] drive_pos = bit_pos(bit_order, len, drive_idx);
    wire logic [3:0] first_pos = bit_pos(bit_order, len, 4'h0);
    wire logic [3:0] sample_pos = bit_pos(bit_order, len, bit_idx);
    wire logic rx_ev = master ? rx_d2[5] : sample_ev;
    wire logic rx_done = master ? rx_d2[4] : word_done;
    wire logic [3:0] rx_pos = master ? rx_d2[3:0] : sample_pos;
    // [RL7] [RL9]
    wire logic ovr_set = rx_done && receive_enable && rx_unread && cont_mode;
    wire logic [DATA_W-1:0] load_word = transmit_enable ? transmit_buffer : '0;

    always_comb begin
        next_rx_word = rx_word;
        if (rx_ev) begin
            next_rx_word[rx_pos] = si_s;
        end
    end

    // ********************************
    // divider and pin synchronisers
    // ********************************
    csp_clkdiv u_div (
        .i_ref_clk(i_ref_clk),
        .i_rst(i_rst),
        .i_clear((state == ST_IDLE) || !master),
        .i_sel(clock_select),
        .o_tick(tick)
    );

    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            // clock pin idles high after reset, so no false edge
            sck_m1 <= 1'b1;
            sck_s <= 1'b1;
            sck_d <= 1'b1;
            si_m1 <= 1'b0;
            si_s <= 1'b0;
        end else begin
            sck_m1 <= i_sck;
            sck_s <= sck_m1;
            sck_d <= sck_s;
            si_m1 <= i_si;
            si_s <= si_m1;
        end
    end

    // ********************************
    // control registers
    // ********************************
    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            serial_control_0 <= CTL_RESET;
            serial_control_1 <= CTL_RESET;
            serial_length_control <= LEN_DEFAULT_SEL;
            transmit_buffer <= '0;
        end else begin
            if (wr_ctl0) begin
                serial_control_0 <= i_wdata[7:0];
            end
            if (wr_ctl1) begin
                serial_control_1 <= i_wdata[7:0];
            end
            if (wr_len) begin
                serial_length_control <= i_wdata[3:0];
            end
            if (wr_tx) begin
                transmit_buffer <= i_wdata;
            end
        end
    end

    // ********************************
    // request and status flags
    // ********************************
    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            tx_pending <= 1'b0;
            rx_dummy <= 1'b0;
        end else begin
            if (wr_tx) begin
                tx_pending <= 1'b1;
            end else if (load && transmit_enable) begin
                tx_pending <= 1'b0;
            end
            if (rd_rx && !transmit_enable) begin
                rx_dummy <= 1'b1;
            end else if (load && !transmit_enable) begin
                rx_dummy <= 1'b0;
            end
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            overrun_flag <= 1'b0;
            rx_unread <= 1'b0;
        end else begin
            if (ovr_set) begin
                overrun_flag <= 1'b1; // [RL7]
            end else if (wr_stat && !i_wdata[B_OVE]) begin
                overrun_flag <= 1'b0; // [RL4] [RL21]
            end
            if (rx_done && receive_enable) begin
                rx_unread <= 1'b1;
            end else if (rd_rx) begin
                rx_unread <= 1'b0;
            end
        end
    end

    // ********************************
    // shift engine
    // ********************************
    always_ff @(posedge i_ref_clk) begin
        if (i_rst || !operation_enable) begin
            state <= ST_IDLE;
        end else if (load) begin
            state <= ST_LEAD;
        end else if (lead_ev) begin
            state <= ST_TRAIL;
        end else if (trail_ev) begin
            state <= last_bit ? ST_IDLE : ST_LEAD; // [RL2]
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_rst || !operation_enable) begin
            transfer_in_progress <= 1'b0;
        end else if (load) begin
            transfer_in_progress <= 1'b1; // [RL20]
        end else if (word_done) begin
            transfer_in_progress <= 1'b0; // [RL2] [RL6]
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_rst || !operation_enable) begin
            bit_idx <= 4'h0;
            sck_lvl <= 1'b1;
            so_latch <= 1'b0;
        end else begin
            if (load) begin
                bit_idx <= 4'h0;
            end else if (trail_ev && !last_bit) begin
                bit_idx <= 4'(bit_idx + 4'h1);
            end
            if (lead_ev) begin
                sck_lvl <= !idle_lvl;
            end else begin
                sck_lvl <= (state == ST_IDLE) ? idle_lvl :
                           (trail_ev ? idle_lvl : sck_lvl);
            end
            if (load && data_phase) begin
                so_latch <= load_word[first_pos];
            end else if (drive_ev) begin
                so_latch <= shift_word[drive_pos];
            end
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            shift_word <= '0;
            rx_word <= '0;
            receive_buffer <= '0;
            rx_d1 <= '0;
            rx_d2 <= '0;
        end else begin
            if (load) begin
                shift_word <= load_word;
            end
            rx_word <= next_rx_word;
            rx_d1 <= {sample_ev, word_done, sample_pos};
            rx_d2 <= rx_d1;
            if (rx_done && receive_enable) begin
                receive_buffer <= next_rx_word; // [RL8]
            end
        end
    end

    // ********************************
    // event pulses
    // ********************************
    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            o_tx_buffer_empty_irq <= 1'b0;
            o_rx_end_irq <= 1'b0;
            o_rx_error_irq <= 1'b0;
        end else begin
            o_tx_buffer_empty_irq <= load && transmit_enable; // [RL1]
            o_rx_end_irq <= rx_done; // [RL6]
            o_rx_error_irq <= ovr_set; // [RL9]
        end
    end

    // ********************************
    // read port
    // ********************************
    wire logic [DATA_W-1:0] stat_word = DATA_W'(
        {transfer_in_progress, 6'h00, overrun_flag});
    wire logic [DATA_W-1:0] rd_mux =
        (i_addr == ADDR_CTL0) ? DATA_W'(serial_control_0) :
        (i_addr == ADDR_CTL1) ? DATA_W'(serial_control_1) :
        (i_addr == ADDR_LEN) ? DATA_W'(serial_length_control) :
        (i_addr == ADDR_STATUS) ? stat_word :
        (i_addr == ADDR_TX) ? transmit_buffer :
        (i_addr == ADDR_RX) ? receive_buffer : '0;

    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            o_rdata <= '0;
        end else if (i_rd) begin
            o_rdata <= rd_mux;
        end
    end

    // ********************************
    // pins
    // ********************************
    // [RL11] [RL12]
    assign o_sck_oe = operation_enable ? master : (clock_select != CKS_EXT);
    assign o_sck_out = (operation_enable && master) ? sck_lvl : idle_lvl;
    // [RL13] [RL14]
    wire logic so_off = !transmit_enable ? 1'b0 :
                        !data_phase ? so_latch :
                        bit_order ? transmit_buffer[B_LOW0] :
                        transmit_buffer[B_LOW7];
    assign o_so = operation_enable ? (transmit_enable && so_latch) : so_off;

    // ********************************
    // assertions
    // ********************************
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (i_rst);

    a_busy_clear_end: assert property (
        word_done && !load |=> !transfer_in_progress) // [RL2]
        else $error("busy flag still set after last edge");
    a_empty_on_load: assert property (
        (state == ST_IDLE) && start_req && transmit_enable
        |=> o_tx_buffer_empty_irq ##1 !o_tx_buffer_empty_irq) // [RL1]
        else $error("no buffer-empty pulse on load");
    a_overrun_set: assert property (
        ovr_set |=> overrun_flag && o_rx_error_irq) // [RL7]
        else $error("overrun not flagged");
    a_overrun_clear: assert property (
        wr_stat && !i_wdata[B_OVE] && !ovr_set |=> !overrun_flag) // [RL4]
        else $error("overrun flag not cleared by write of 0");
    a_overrun_no_set: assert property (
        !overrun_flag && wr_stat && !ovr_set |=> !overrun_flag) // [RL21]
        else $error("overrun flag set by software");
    a_rx_overwrite: assert property (
        rx_done && receive_enable && rx_unread
        |=> receive_buffer == $past(next_rx_word)) // [RL8]
        else $error("receive buffer not overwritten");
    a_sck_powered_off: assert property (
        !operation_enable |-> (o_sck_oe == (clock_select != CKS_EXT)) &&
        (!o_sck_oe || (o_sck_out == !clock_polarity))) // [RL11]
        else $error("clock pin wrong while powered off");
    a_so_powered_off: assert property (
        !operation_enable && !transmit_enable |-> !o_so) // [RL13]
        else $error("data pin not low while disabled");
    a_cont_no_gap: assert property (
        word_done && load && master
        |=> (state == ST_LEAD) && transfer_in_progress) // [RL22]
        else $error("continuous transfer paused");
    a_slave_end: assert property (
        word_done && !master && !load
        |=> !transfer_in_progress && o_rx_end_irq) // [RL6]
        else $error("slave sequence did not end");
    a_div_two: assert property (
        master && (clock_select == 3'h0) && (state != ST_IDLE)
        |-> tick) // [RL15]
        else $error("select 000 not a half-period per cycle");

    c_master_word: cover property (word_done && master);
    c_overrun: cover property (ovr_set);
    c_slave_end: cover property (word_done && !master && !load);
    c_cont_chain: cover property (word_done && load);
endmodule

// *** test/csp_peer.sv ***
// serial peer: answers on the clock line, or drives it as master
// assumes type 1 timing, 8-bit words, msb first, clock idles high
`timescale 1ns/1ps
module csp_peer (
    // clock
    input wire logic i_ref_clk,
    // serial lines
    input wire logic i_sck_line,
    input wire logic i_so,
    output logic o_si,
    output logic o_sck
);
    logic [7:0] tx_q[$];
    logic [7:0] rx_q[$];
    logic [7:0] sh_out;
    logic [7:0] sh_in;
    logic in_word;
    int nbit;
    int quiet;
    initial begin
        o_si = 1'b0;
        o_sck = 1'b1;
        in_word = 1'b0;
        nbit = 0;
        quiet = 0;
        sh_out = 8'h00;
        sh_in = 8'h00;
    end
    // ********************************
    // line behaviour
    // ********************************
    // released data line: holds a little, then changes every cycle
    always @(posedge i_ref_clk) begin
        if (!in_word) begin
            quiet <= quiet + 1;
            if (quiet >= 3) o_si <= ~o_si;
        end
    end
    // data changes on the leading (falling) edge
    always @(negedge i_sck_line) begin
        if (nbit == 0) sh_out = tx_q.size() > 0 ? tx_q.pop_front() : 8'h00;
        in_word = 1'b1;
        o_si = sh_out[7 - nbit];
    end
    // data sampled on the trailing (rising) edge
    always @(posedge i_sck_line) begin
        if (in_word) begin
            sh_in = {sh_in[6:0], i_so};
            nbit = nbit + 1;
            if (nbit == 8) begin
                rx_q.push_back(sh_in);
                nbit = 0;
                in_word = 1'b0;
                quiet = 0;
            end
        end
    end
    // one word as master; clock stands high outside it
    task automatic clock_word(input int half);
        repeat (8) begin
            o_sck <= 1'b0;
            repeat (half) @(posedge i_ref_clk);
            o_sck <= 1'b1;
            repeat (half) @(posedge i_ref_clk);
        end
    endtask
endmodule

// *** test/testbench.sv ***
// self-checking bench of the clocked serial port
// assumes csp_top with a register port and the serial peer model
`timescale 1ns/1ps
module testbench;
    import csp_pkg::*;
    logic i_ref_clk, i_rst, i_wr, i_rd, o_so, si, m_sck;
    logic o_sck_out, o_sck_oe, txe_irq, rxe_irq, err_irq;
    logic [2:0] i_addr;
    logic [15:0] i_wdata, o_rdata, s;
    logic [7:0] d[6];
    logic [7:0] p[6];
    logic [7:0] tx;
    logic [2:0] mb;
    wire sck_line = o_sck_oe ? o_sck_out : m_sck;
    int error_cnt = 0, n_checks = 0, cyc = 0;
    int n_txe = 0, n_rxe = 0, n_err = 0, n_low = 0, b;
    csp_top u_dut (.i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_addr(i_addr),
        .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
        .o_tx_buffer_empty_irq(txe_irq), .o_rx_end_irq(rxe_irq),
        .o_rx_error_irq(err_irq), .i_sck(sck_line), .o_sck_out(o_sck_out),
        .o_sck_oe(o_sck_oe), .i_si(si), .o_so(o_so));
    csp_peer u_peer (.i_ref_clk(i_ref_clk), .i_sck_line(sck_line),
        .i_so(o_so), .o_si(si), .o_sck(m_sck));
    initial begin
        i_ref_clk = 1'b0;
        forever #12.5 i_ref_clk = ~i_ref_clk;
    end
    // ********************************
    // monitors and timeout
    // ********************************
    always @(posedge i_ref_clk) begin
        cyc <= cyc + 1;
        if (txe_irq === 1'b1) n_txe <= n_txe + 1;
        if (rxe_irq === 1'b1) n_rxe <= n_rxe + 1;
        if (err_irq === 1'b1) n_err <= n_err + 1;
        if (o_sck_oe === 1'b1 && o_sck_out === 1'b0) n_low <= n_low + 1;
        if (cyc == 20000) begin
            $display("[FAIL] run_time expected below 20000 seen %0d", cyc);
            error_cnt++;
            summarize();
        end
    end
    // ********************************
    // tasks
    // ********************************
    task automatic summarize();
        $display("checks %0d mismatches %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [15:0] e,
                       input logic [15:0] g);
        n_checks++;
        if (g !== e) begin
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
            error_cnt++;
        end
    endtask
    task automatic wr(input logic [2:0] a, input logic [15:0] v);
        @(posedge i_ref_clk);
        i_addr <= a;
        i_wdata <= v;
        i_wr <= 1'b1;
        @(posedge i_ref_clk);
        i_wr <= 1'b0;
    endtask
    task automatic rd(input logic [2:0] a);
        @(posedge i_ref_clk);
        i_addr <= a;
        i_rd <= 1'b1;
        @(posedge i_ref_clk);
        i_rd <= 1'b0;
        @(negedge i_ref_clk);
        s = o_rdata;
    endtask
    task automatic rchk(input string nm, input logic [2:0] a,
                        input logic [15:0] e);
        rd(a);
        chk(nm, e, s);
    endtask
    task automatic wait_cnt(ref int c, input int t, input string nm);
        int k;
        k = 0;
        while (c < t && k < 600) begin
            @(posedge i_ref_clk);
            k++;
        end
        chk(nm, 16'(t), 16'(c));
    endtask
    task automatic wait_idle();
        int k;
        k = 0;
        s = 16'h0080;
        while (s[B_TSF] !== 1'b0 && k < 100) begin
            rd(ADDR_STATUS);
            k++;
        end
        // receive events trail the busy flag by a few cycles
        repeat (4) @(posedge i_ref_clk);
        chk("busy", 16'h0000, {15'h0000, s[B_TSF]});
    endtask
    function automatic logic exp_so(input logic [2:0] m, input logic [7:0] v);
        if (!m[2] || !m[1]) return 1'b0;
        return m[0] ? v[0] : v[7];
    endfunction
    // ********************************
    // main sequence
    // ********************************
    initial begin
        void'($urandom(32'h2d51));
        {i_rst, i_wr, i_rd, i_addr, i_wdata} = {1'b1, 21'h000000};
        for (int k = 0; k < 6; k++) begin
            d[k] = 8'($urandom);
            p[k] = 8'($urandom);
            u_peer.tx_q.push_back(p[k]);
        end
        repeat (5) @(posedge i_ref_clk);
        i_rst <= 1'b0;
        @(negedge i_ref_clk);
        chk("sck pins", 16'h0003, {14'h0, o_sck_oe, o_sck_out});
        chk("so", 16'h0000, {15'h0, o_so});
        rchk("ctl0", ADDR_CTL0, 16'h0000);
        rchk("status", ADDR_STATUS, 16'h0000);
        rchk("unmapped", 3'h6, 16'h0000);
        $display("test reset done");
        wr(ADDR_LEN, 16'h0000);
        wr(ADDR_CTL1, 16'h0000);
        wr(ADDR_CTL0, 16'h00e2);
        n_low = 0;
        wr(ADDR_TX, {8'h00, d[0]});
        wait_cnt(n_txe, 1, "tx empty");
        rchk("busy set", ADDR_STATUS, 16'h0080);
        wr(ADDR_TX, {8'h00, d[1]});
        wait_cnt(n_rxe, 1, "rx end");
        rchk("rx0", ADDR_RX, {8'h00, p[0]});
        wait_cnt(n_rxe, 2, "rx end");
        rchk("rx1", ADDR_RX, {8'h00, p[1]});
        wait_idle();
        chk("sck lows", 16'd16, 16'(n_low));
        chk("err irq", 16'h0000, 16'(n_err));
        for (int k = 0; k < 2; k++)
            chk("peer rx", {8'h00, d[k]}, {8'h00, u_peer.rx_q.pop_front()});
        $display("test master chain done");
        b = n_txe;
        for (int k = 2; k < 5; k++) begin
            wr(ADDR_TX, {8'h00, d[k]});
            wait_cnt(n_txe, b + k - 1, "tx empty");
        end
        wait_idle();
        chk("err irq", 16'h0002, 16'(n_err));
        rchk("ovr set", ADDR_STATUS, 16'h0001);
        wr(ADDR_STATUS, 16'h0001);
        rchk("ovr w1", ADDR_STATUS, 16'h0001);
        wr(ADDR_STATUS, 16'h0000);
        rchk("ovr w0", ADDR_STATUS, 16'h0000);
        rchk("rx last", ADDR_RX, {8'h00, p[4]});
        for (int k = 2; k < 5; k++)
            chk("peer rx", {8'h00, d[k]}, {8'h00, u_peer.rx_q.pop_front()});
        $display("test overrun done");
        wr(ADDR_CTL0, 16'h0000);
        wr(ADDR_CTL1, 16'h0007);
        wr(ADDR_CTL0, 16'h00e2);
        @(negedge i_ref_clk);
        chk("slave oe", 16'h0000, {15'h0, o_sck_oe});
        b = n_rxe;
        wr(ADDR_TX, {8'h00, d[5]});
        u_peer.clock_word(6);
        wait_cnt(n_rxe, b + 1, "slave end");
        wait_idle();
        rchk("slave rx", ADDR_RX, {8'h00, p[5]});
        chk("peer rx", {8'h00, d[5]}, {8'h00, u_peer.rx_q.pop_front()});
        $display("test slave done");
        wr(ADDR_CTL0, 16'h0000);
        tx = 8'($urandom);
        u_peer.tx_q.push_back(tx);
        wr(ADDR_CTL1, 16'h0001);
        wr(ADDR_CTL0, 16'h00a0);
        b = n_rxe;
        rd(ADDR_RX);
        wait_cnt(n_rxe, b + 1, "rx only end");
        rchk("rx only", ADDR_RX, {8'h00, tx});
        wait_idle();
        $display("test receive only done");
        wr(ADDR_CTL0, 16'h0000);
        for (int k = 0; k < 6; k++) begin
            mb = (k % 3 == 0) ? 3'h0 : (k % 3 == 1) ? 3'h3 : CKS_EXT;
            wr(ADDR_CTL1, {11'h0, 1'(k / 3), 1'b0, mb});
            @(negedge i_ref_clk);
            chk("off oe", {15'h0, mb != CKS_EXT}, {15'h0, o_sck_oe});
            if (mb != CKS_EXT)
                chk("off sck", {15'h0, k < 3}, {15'h0, o_sck_out});
        end
        tx = (8'($urandom) | 8'h80) & 8'hfe;
        wr(ADDR_TX, {8'h00, tx});
        for (int m = 0; m < 8; m++) begin
            mb = 3'(m);
            wr(ADDR_CTL1, {11'h0, 1'b0, mb[1], 3'h0});
            wr(ADDR_CTL0, {8'h00, 1'b0, mb[2], 1'b0, mb[0], 4'h0});
            @(negedge i_ref_clk);
            chk("off so", {15'h0, exp_so(mb, tx)}, {15'h0, o_so});
        end
        $display("test powered off pins done");
        summarize();
    end
endmodule
